// ==== src/chdl_cfg_regs.sv ====
// Strobed register access was decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: Bit 4 of hood control routes management interrupt to IRQ2; resets off.
// RULE2: Bit 3 of hood control picks unlock (0, reset) or lock (1).
// RULE3: Writing 1 to bit 2 starts the operation; bit reads 1 while busy.
// RULE4: Writing 0 to bit 2 during an operation stops it.
// RULE5: Software checks bit 2 is 0 before starting a new operation.
// RULE6: Bits 1-0 pick pin 128: general I/O, fan tach, hood unlock, reserved.
// RULE7: Disable register writes blocked by selected external lock or software lock.
// RULE8: Software lock bit stays set until hardware reset.
// RULE9: With software lock set, disable bits 0-6 are read-only.
// RULE10: Disable bits 4-0 turn off five logical devices; reset enabled.
// RULE11: Device active needs clear disable, own activate bit and global enable.
// RULE12: Index 27h returns a fixed revision; writes ignored.
// RULE13: External lock counts only when pin 53 selects the lock function.
// RULE14: Disable bits 6-5 are plain scratch storage.
// RULE15: Hood control bits 7-5 read zero and ignore writes.
module chdl_cfg_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic external_write_lock_in,
  input wire logic pin53_lock_sel_in,
  input wire logic smi_in,
  input wire logic first_global_config_en_in,
  input wire logic [chdl_pkg::CHDL_NUM_DEV-1:0] dev_activate_in,
  input wire logic third_fan_tach_in,
  input wire logic pin128_general_io_in,
  input wire logic pin128_gpio_out_in,
  input wire logic pin128_gpio_oe_in,
  output logic irq2_out,
  output logic hood_lock_drive_out,
  output logic hood_unlock_drive_out,
  output logic pin128_out,
  output logic pin128_oe_out,
  output logic third_fan_tach_out,
  output logic pin128_general_io_out,
  output logic [chdl_pkg::CHDL_NUM_DEV-1:0] dev_active_out
);
  import chdl_pkg::*;

  logic [7:0] hood_r, hood_nxt;
  logic [7:0] ddis_r, ddis_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq2_r, irq2_nxt;
  logic lkd_r, lkd_nxt;
  logic ulkd_r, ulkd_nxt;
  logic p128_r, p128_nxt;
  logic p128_oe_r, p128_oe_nxt;
  logic tach_r, tach_nxt;
  logic gpi_r, gpi_nxt;
  logic [CHDL_NUM_DEV-1:0] act_r;
  logic [CHDL_NUM_DEV-1:0] act_nxt;
  logic busy;
  logic lock_drv;
  logic unlock_drv;
  logic start_op;
  logic stop_op;
  logic wr_hood;
  logic wr_ddis;
  logic ddis_blocked;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    return a == idx;
  endfunction

  assign wr_hood = wr_in && hit(addr_in, CHDL_IDX_HOOD_CTRL);
  assign wr_ddis = wr_in && hit(addr_in, CHDL_IDX_DEV_DISABLE);
  // RULE3 start on written one
  assign start_op = wr_hood && wdata_in[CHDL_BIT_HOOD_ACT] && !busy;
  // RULE4 stop on written zero
  assign stop_op = wr_hood && !wdata_in[CHDL_BIT_HOOD_ACT];
  // RULE7 write block terms
  // RULE13 lock needs pin select
  assign ddis_blocked = (external_write_lock_in && pin53_lock_sel_in) ||
                        ddis_r[CHDL_BIT_SW_LOCK];

  chdl_hood_actuator u_act (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(start_op),
    .stop_in(stop_op),
    // RULE2 direction from write
    .lock_sel_in(wdata_in[CHDL_BIT_HOOD_LOCK]),
    .busy_out(busy),
    .lock_drive_out(lock_drv),
    .unlock_drive_out(unlock_drv)
  );

  chdl_dev_gate u_gate (
    .disable_in(ddis_r[CHDL_NUM_DEV-1:0]),
    .activate_in(dev_activate_in),
    .global_en_in(first_global_config_en_in),
    .active_out(act_nxt)
  );

  always_comb begin
    hood_nxt = hood_r;
    ddis_nxt = ddis_r;
    // RULE15 reserved bits held zero
    if (wr_hood) begin
      hood_nxt = wdata_in & CHDL_HOOD_CTRL_MASK;
    end
    // RULE3 status mirrors busy
    hood_nxt[CHDL_BIT_HOOD_ACT] = 1'b0;
    // RULE7 blocked disable writes
    // RULE9 low bits read-only when locked
    // RULE14 scratch bits stored
    if (wr_ddis && !ddis_blocked) begin
      ddis_nxt = (ddis_r & ~CHDL_DEV_LOW_MASK) | (wdata_in & CHDL_DEV_LOW_MASK);
      // RULE8 sticky software lock
      if (wdata_in[CHDL_BIT_SW_LOCK]) begin
        ddis_nxt[CHDL_BIT_SW_LOCK] = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        CHDL_IDX_HOOD_CTRL: begin
          rdata_nxt = hood_r;
          rdata_nxt[CHDL_BIT_HOOD_ACT] = busy;
        end
        CHDL_IDX_DEV_DISABLE: rdata_nxt = ddis_r;
        // RULE12 fixed revision
        CHDL_IDX_SIL_REV: rdata_nxt = CHDL_SIL_REV_VALUE;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb begin
    // RULE1 interrupt routing
    irq2_nxt = hood_r[CHDL_BIT_SMI_IRQ2] && smi_in;
    lkd_nxt = lock_drv;
    ulkd_nxt = 1'b0;
    p128_nxt = 1'b0;
    p128_oe_nxt = 1'b0;
    tach_nxt = 1'b0;
    gpi_nxt = 1'b0;
    // RULE6 pin 128 function mux
    case (hood_r[1:0])
      CHDL_PIN128_GPIO: begin
        p128_nxt = pin128_gpio_out_in;
        p128_oe_nxt = pin128_gpio_oe_in;
        gpi_nxt = pin128_general_io_in;
      end
      CHDL_PIN128_FAN_TACH: tach_nxt = third_fan_tach_in;
      CHDL_PIN128_UNLOCK: begin
        // RULE2 unlock drive
        ulkd_nxt = unlock_drv;
        p128_nxt = unlock_drv;
        p128_oe_nxt = 1'b1;
      end
      default: p128_oe_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hood_r <= CHDL_HOOD_CTRL_RESET;
      ddis_r <= CHDL_DEV_DISABLE_RESET;
      rdata_r <= 8'h00;
      irq2_r <= 1'b0;
      lkd_r <= 1'b0;
      ulkd_r <= 1'b0;
      p128_r <= 1'b0;
      p128_oe_r <= 1'b0;
      tach_r <= 1'b0;
      gpi_r <= 1'b0;
      act_r <= '0;
    end else begin
      hood_r <= hood_nxt;
      ddis_r <= ddis_nxt;
      rdata_r <= rdata_nxt;
      irq2_r <= irq2_nxt;
      lkd_r <= lkd_nxt;
      ulkd_r <= ulkd_nxt;
      p128_r <= p128_nxt;
      p128_oe_r <= p128_oe_nxt;
      tach_r <= tach_nxt;
      gpi_r <= gpi_nxt;
      // RULE10 disabled devices inactive
      act_r <= act_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign irq2_out = irq2_r;
  assign hood_lock_drive_out = lkd_r;
  assign hood_unlock_drive_out = ulkd_r;
  assign pin128_out = p128_r;
  assign pin128_oe_out = p128_oe_r;
  assign third_fan_tach_out = tach_r;
  assign pin128_general_io_out = gpi_r;
  assign dev_active_out = act_r;

  // Interrupt routing follows the enable bit with one cycle of lag.
  chk_irq2_route: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
    !hood_r[CHDL_BIT_SMI_IRQ2] |=> !irq2_out)
    else $error("irq2 driven while routing disabled");
  chk_irq2_follow: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
    hood_r[CHDL_BIT_SMI_IRQ2] && smi_in |=> irq2_out)
    else $error("irq2 missed a routed interrupt");

  // The direction comes from bit 3 of the same write that starts the operation.
  chk_lock_dir: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
    start_op && !wdata_in[CHDL_BIT_HOOD_LOCK] |=> ##1 !hood_lock_drive_out)
    else $error("lock drive during unlock operation");
  chk_lock_start: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
    start_op && wdata_in[CHDL_BIT_HOOD_LOCK] |=> ##1 hood_lock_drive_out)
    else $error("lock drive missing during lock operation");
  chk_no_unlock: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
    start_op && wdata_in[CHDL_BIT_HOOD_LOCK] |=> ##1 !hood_unlock_drive_out)
    else $error("unlock drive during lock operation");

  // The action bit reads the live busy state; a written zero aborts.
  chk_busy_read: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
    rd_in && addr_in == CHDL_IDX_HOOD_CTRL |=> rdata_out[CHDL_BIT_HOOD_ACT] == $past(busy))
    else $error("action bit does not show busy");
  chk_start_busy: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
    start_op |=> busy)
    else $error("hood operation did not start");
  chk_stop_idle: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
    stop_op |=> !busy)
    else $error("written zero left hood operation busy");
  chk_stop_drives: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
    busy && stop_op |=> ##1 !hood_lock_drive_out && !hood_unlock_drive_out)
    else $error("hood drive stayed on after stop");

  // Pin 128 carries at most one function at a time; the reserved setting carries none.
  chk_pin_unlock: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] == CHDL_PIN128_UNLOCK |=> pin128_oe_out)
    else $error("pin 128 not driven in unlock mode");
  chk_pin_unlock_val: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] == CHDL_PIN128_UNLOCK |=> pin128_out == $past(unlock_drv))
    else $error("pin 128 does not carry unlock drive");
  chk_tach_route: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] == CHDL_PIN128_FAN_TACH |=> third_fan_tach_out == $past(third_fan_tach_in))
    else $error("fan tach input not routed");
  chk_tach_off: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] != CHDL_PIN128_FAN_TACH |=> !third_fan_tach_out)
    else $error("fan tach routed while not selected");
  chk_gpio_route: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] == CHDL_PIN128_GPIO |=> pin128_oe_out == $past(pin128_gpio_oe_in)
      && pin128_general_io_out == $past(pin128_general_io_in))
    else $error("pin 128 general I/O not routed");
  chk_gpio_off: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    hood_r[1:0] != CHDL_PIN128_GPIO |=> !pin128_general_io_out)
    else $error("general I/O routed while not selected");
  chk_reserved_pin: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
    &hood_r[1:0] |=> !pin128_oe_out && !pin128_out)
    else $error("pin 128 driven in reserved mode");

  // Disable register write protection and sticky lock.
  chk_write_block: assert property (@(posedge clock_in) disable iff (rst_in) // RULE7
    wr_ddis && ddis_blocked |=> ddis_r == $past(ddis_r))
    else $error("blocked write changed disable register");
  chk_ext_block: assert property (@(posedge clock_in) disable iff (rst_in) // RULE13
    wr_ddis && external_write_lock_in && pin53_lock_sel_in |=> $stable(ddis_r))
    else $error("selected lock input did not block write");
  chk_ext_lock: assert property (@(posedge clock_in) disable iff (rst_in) // RULE13
    wr_ddis && !pin53_lock_sel_in && !ddis_r[CHDL_BIT_SW_LOCK]
      |=> ddis_r[6:0] == $past(wdata_in[6:0]))
    else $error("unselected lock input blocked write");
  chk_sw_lock: assert property (@(posedge clock_in) disable iff (rst_in) // RULE8
    ddis_r[CHDL_BIT_SW_LOCK] |=> ddis_r[CHDL_BIT_SW_LOCK])
    else $error("software lock cleared without reset");
  chk_lock_set: assert property (@(posedge clock_in) disable iff (rst_in) // RULE8
    wr_ddis && !ddis_blocked && wdata_in[CHDL_BIT_SW_LOCK] |=> ddis_r[CHDL_BIT_SW_LOCK])
    else $error("software lock not set by write");
  chk_low_ro: assert property (@(posedge clock_in) disable iff (rst_in) // RULE9
    ddis_r[CHDL_BIT_SW_LOCK] |=> $stable(ddis_r[6:0]))
    else $error("locked bits changed");
  chk_scratch_store: assert property (@(posedge clock_in) disable iff (rst_in) // RULE14
    wr_ddis && !ddis_blocked |=> ddis_r[6:5] == $past(wdata_in[6:5]))
    else $error("scratch bits not stored");

  // Device activation combines disable, activate and global enable.
  chk_dev_off: assert property (@(posedge clock_in) disable iff (rst_in) // RULE10
    ddis_r[0] |=> !dev_active_out[0])
    else $error("disabled device shown active");
  chk_dev_off_all: assert property (@(posedge clock_in) disable iff (rst_in) // RULE10
    (dev_active_out & $past(ddis_r[CHDL_NUM_DEV-1:0])) == '0)
    else $error("a disabled device shown active");
  chk_dev_on: assert property (@(posedge clock_in) disable iff (rst_in) // RULE11
    !ddis_r[4] && dev_activate_in[4] && first_global_config_en_in
      |=> dev_active_out[4])
    else $error("enabled device not shown active");
  chk_global_off: assert property (@(posedge clock_in) disable iff (rst_in) // RULE11
    !first_global_config_en_in |=> dev_active_out == '0)
    else $error("device active without global enable");

  // Revision register and reserved bits.
  chk_rev_read: assert property (@(posedge clock_in) disable iff (rst_in) // RULE12
    rd_in && addr_in == CHDL_IDX_SIL_REV |=> rdata_out == CHDL_SIL_REV_VALUE)
    else $error("revision read wrong");
  chk_rev_write: assert property (@(posedge clock_in) disable iff (rst_in) // RULE12
    wr_in && addr_in == CHDL_IDX_SIL_REV |=> $stable(hood_r) && $stable(ddis_r))
    else $error("revision write changed a register");
  chk_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in) // RULE15
    hood_r[7:5] == 3'h0)
    else $error("reserved hood bits set");
  chk_reserved_read: assert property (@(posedge clock_in) disable iff (rst_in) // RULE15
    rd_in && addr_in == CHDL_IDX_HOOD_CTRL |=> rdata_out[7:5] == 3'h0)
    else $error("reserved hood bits read nonzero");
endmodule

// ==== src/chdl_dev_gate.sv ====
`timescale 1ns/10ps
module chdl_dev_gate (
  input wire logic [chdl_pkg::CHDL_NUM_DEV-1:0] disable_in,
  input wire logic [chdl_pkg::CHDL_NUM_DEV-1:0] activate_in,
  input wire logic global_en_in,
  output logic [chdl_pkg::CHDL_NUM_DEV-1:0] active_out
);
  import chdl_pkg::*;
  // RULE11 combine activation terms
  for (genvar i = 0; i < CHDL_NUM_DEV; i++) begin : g_dev
    assign active_out[i] = !disable_in[i] && activate_in[i] && global_en_in;
  end
endmodule

// ==== src/chdl_hood_actuator.sv ====
`timescale 1ns/10ps
module chdl_hood_actuator (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic lock_sel_in,
  output logic busy_out,
  output logic lock_drive_out,
  output logic unlock_drive_out
);
  import chdl_pkg::*;
  chdl_hood_state_t state_r, state_nxt;
  logic [CHDL_ACT_CNT_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      CHDL_IDLE: begin
        // RULE3 start operation
        if (start_in) begin
          state_nxt = lock_sel_in ? CHDL_LOCKING : CHDL_UNLOCKING;
          cnt_nxt = CHDL_ACT_CNT_W'(CHDL_ACT_CYCLES - 1);
        end
      end
      CHDL_LOCKING, CHDL_UNLOCKING: begin
        // RULE4 abort on clear
        if (stop_in || cnt_r == '0) begin
          state_nxt = CHDL_IDLE;
        end else begin
          cnt_nxt = cnt_r - CHDL_ACT_CNT_W'(1);
        end
      end
      default: state_nxt = CHDL_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= CHDL_IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign busy_out = (state_r != CHDL_IDLE);
  assign lock_drive_out = (state_r == CHDL_LOCKING);
  assign unlock_drive_out = (state_r == CHDL_UNLOCKING);

  // Operation length is bounded by the actuation time.
  chk_busy_ends: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
    $rose(busy_out) |-> ##[1:250] !busy_out)
    else $error("hood operation did not finish in time");
  chk_stop_aborts: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
    busy_out && stop_in |=> !busy_out)
    else $error("stop did not end hood operation");
endmodule

// ==== src/chdl_pkg.sv ====
package chdl_pkg;
  localparam logic [7:0] CHDL_IDX_HOOD_CTRL = 8'h25;
  localparam logic [7:0] CHDL_IDX_DEV_DISABLE = 8'h26;
  localparam logic [7:0] CHDL_IDX_SIL_REV = 8'h27;
  localparam logic [7:0] CHDL_HOOD_CTRL_RESET = 8'h00;
  localparam logic [7:0] CHDL_DEV_DISABLE_RESET = 8'h00;
  // Revision value is arbitrary.
  localparam logic [7:0] CHDL_SIL_REV_VALUE = 8'h01;
  localparam int CHDL_BIT_SMI_IRQ2 = 4;
  localparam int CHDL_BIT_HOOD_LOCK = 3;
  localparam int CHDL_BIT_HOOD_ACT = 2;
  localparam int CHDL_BIT_SW_LOCK = 7;
  localparam int CHDL_NUM_DEV = 5;
  localparam logic [1:0] CHDL_PIN128_GPIO = 2'h0;
  localparam logic [1:0] CHDL_PIN128_FAN_TACH = 2'h1;
  localparam logic [1:0] CHDL_PIN128_UNLOCK = 2'h2;
  localparam logic [7:0] CHDL_HOOD_CTRL_MASK = 8'h1F;
  localparam logic [7:0] CHDL_DEV_LOW_MASK = 8'h7F;
  localparam int CHDL_ACT_TIME_NS = 1000;
  localparam int CHDL_CLK_PERIOD_NS = 4;
  localparam int CHDL_ACT_CYCLES = CHDL_ACT_TIME_NS / CHDL_CLK_PERIOD_NS;
  localparam int CHDL_ACT_CNT_W = 8;
  typedef enum logic [1:0] {CHDL_IDLE, CHDL_LOCKING, CHDL_UNLOCKING} chdl_hood_state_t;
endpackage

// ==== verification/chdl_cfg_regs_tb.sv ====
`timescale 1ns/10ps
module chdl_cfg_regs_tb;
  import chdl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic sel53 = 1'b0;
  logic smi = 1'b0;
  logic gen = 1'b1;
  logic [4:0] act = 5'h1F;
  logic tach = 1'b0;
  logic gio = 1'b0;
  logic gout = 1'b0;
  logic goe = 1'b0;
  logic [7:0] rdata;
  logic irq2, lockd, unlkd, p128, p128oe, tacho, gioo;
  logic [4:0] dact;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  chdl_cfg_regs uut (.clock_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .external_write_lock_in(ext),
    .pin53_lock_sel_in(sel53), .smi_in(smi), .first_global_config_en_in(gen),
    .dev_activate_in(act), .third_fan_tach_in(tach), .pin128_general_io_in(gio),
    .pin128_gpio_out_in(gout), .pin128_gpio_oe_in(goe), .irq2_out(irq2),
    .hood_lock_drive_out(lockd), .hood_unlock_drive_out(unlkd), .pin128_out(p128),
    .pin128_oe_out(p128oe), .third_fan_tach_out(tacho), .pin128_general_io_out(gioo),
    .dev_active_out(dact));

  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The ceiling is far above the few hundred cycles the scenarios need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h00);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h00);
    rd_reg(CHDL_IDX_SIL_REV, CHDL_SIL_REV_VALUE);
    wr_reg(CHDL_IDX_SIL_REV, ~CHDL_SIL_REV_VALUE);
    rd_reg(CHDL_IDX_SIL_REV, CHDL_SIL_REV_VALUE);
    rd_reg(8'h40, 8'h00);
  endtask

  task automatic t_hood_cfg();
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'hE3);
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h03);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h10);
    @(posedge clk) smi <= 1'b1;
    settle();
    chk({7'h00, irq2}, 8'h01);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h00);
    settle();
    chk({7'h00, irq2}, 8'h00);
    @(posedge clk) {gout, goe, gio} <= 3'b111;
    settle();
    chk({4'h0, p128, p128oe, gioo, tacho}, 8'h0E);
    wr_reg(CHDL_IDX_HOOD_CTRL, {6'h00, CHDL_PIN128_FAN_TACH});
    @(posedge clk) tach <= 1'b1;
    settle();
    chk({6'h00, gioo, tacho}, 8'h01);
    wr_reg(CHDL_IDX_HOOD_CTRL, {6'h00, CHDL_PIN128_UNLOCK});
    settle();
    chk({5'h00, gioo, tacho, unlkd}, 8'h00);
    chk({6'h00, p128, p128oe}, 8'h01);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h03);
    settle();
    chk({4'h0, p128, p128oe, gioo, tacho}, 8'h00);
  endtask

  task automatic t_hood_op();
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h03);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h0C);
    settle();
    chk({7'h00, lockd}, 8'h01);
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h0C);
    repeat (100) @(posedge clk);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h0C);
    repeat (100) @(posedge clk);
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h0C);
    repeat (60) @(posedge clk);
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h08);
    chk({7'h00, lockd}, 8'h00);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h06);
    settle();
    chk({6'h00, lockd, unlkd}, 8'h01);
    chk({6'h00, p128, p128oe}, 8'h03);
    wr_reg(CHDL_IDX_HOOD_CTRL, 8'h02);
    settle();
    chk({7'h00, unlkd}, 8'h00);
    rd_reg(CHDL_IDX_HOOD_CTRL, 8'h02);
  endtask

  task automatic t_dev();
    @(posedge clk) ext <= 1'b1;
    wr_reg(CHDL_IDX_DEV_DISABLE, 8'h65);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h65);
    settle();
    chk({3'h0, dact}, 8'h1A);
    @(posedge clk) gen <= 1'b0;
    settle();
    chk({3'h0, dact}, 8'h00);
    @(posedge clk) {gen, act} <= 6'h2F;
    settle();
    chk({3'h0, dact}, 8'h0A);
    @(posedge clk) sel53 <= 1'b1;
    wr_reg(CHDL_IDX_DEV_DISABLE, 8'h00);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h65);
    @(posedge clk) ext <= 1'b0;
    wr_reg(CHDL_IDX_DEV_DISABLE, 8'h12);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h12);
    wr_reg(CHDL_IDX_DEV_DISABLE, 8'h83);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h83);
    wr_reg(CHDL_IDX_DEV_DISABLE, 8'h00);
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h83);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd_reg(CHDL_IDX_DEV_DISABLE, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_hood_cfg();
    t_hood_op();
    t_dev();
    wrap_up();
  end
endmodule
